// ### pms_defs.svh
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

// ==========================================
// Pin group
`define PMS_GPIO_COUNT 32

// ==========================================
// Watchdog rate from the system clock
`define PMS_SYS_CLK_KHZ 25000
`define PMS_WATCHDOG_CLK_KHZ 1500
`define PMS_WATCHDOG_ACC_W 16

`endif

// ### pms_pkg.sv
package pms_pkg;

	// ==========================================
	// Sequencer states
	typedef enum logic [3:0] {
		ST_ACTIVE,
		ST_IDLE,
		ST_ENT_LATCH,
		ST_ENT_SAVE,
		ST_ENT_GATE,
		ST_ENT_PWR,
		ST_STANDBY,
		ST_SHUTDOWN,
		ST_EX_PWR,
		ST_EX_CLK,
		ST_EX_RESTORE,
		ST_EX_UNLATCH,
		ST_RST_HELD,
		ST_BOOT
	} seq_state_type;

	// ==========================================
	// Reported operating mode
	typedef enum logic [2:0] {
		MODE_ACTIVE,
		MODE_IDLE,
		MODE_STANDBY,
		MODE_SHUTDOWN,
		MODE_RESET
	} mode_type;

	// ==========================================
	// Software mode request
	typedef enum logic [1:0] {
		REQ_IDLE,
		REQ_STANDBY,
		REQ_SHUTDOWN
	} req_mode_type;

	// ==========================================
	// Recorded reset cause
	typedef enum logic [1:0] {
		CAUSE_POR,
		CAUSE_PIN,
		CAUSE_WAKE
	} reset_cause_type;

	// ==========================================
	// Per-state domain controls
	typedef struct packed {
		mode_type mode;
		logic cpu_clk;
		logic mem_clk;
		logic flash;
		logic sram;
		logic sram_ret;
		logic periph_pwr;
		logic periph_clk;
		logic supply_duty;
		logic brown_on;
		logic brown_duty;
		logic por_on;
		logic always_on;
		logic sensor;
		logic hs_clk;
		logic ms_clk;
		logic ls_clk;
		logic save;
		logic restore;
		logic latch;
		logic wd_pause;
		logic wd_off;
	} out_type;

endpackage : pms_pkg

// ### pm_ctl_if.sv
`timescale 1ns/1ps
interface pm_ctl_if;
	logic latch_en;
	logic wake_hit;
	logic wd_pause;
	logic wd_off;

	modport seq (output latch_en, output wd_pause, output wd_off, input wake_hit);
	modport io (input latch_en, output wake_hit);
	modport wd (input wd_pause, input wd_off);
endinterface : pm_ctl_if

// ### io_latch.sv
`timescale 1ns/1ps
`include "pms_defs.svh"
module io_latch
	import pms_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Core side of the pins
	input wire logic [`PMS_GPIO_COUNT-1:0] gpio_out_i,
	input wire logic [`PMS_GPIO_COUNT-1:0] gpio_oe_i,
	input wire logic [`PMS_GPIO_COUNT-1:0] wake_pin_en_i,
	// Pad side
	input wire logic [`PMS_GPIO_COUNT-1:0] pad_in_i,
	output logic [`PMS_GPIO_COUNT-1:0] pad_out_o,
	output logic [`PMS_GPIO_COUNT-1:0] pad_oe_o,
	// Sequencer link
	pm_ctl_if.io ctl
);
	logic [`PMS_GPIO_COUNT-1:0] out_d, out_q, oe_d, oe_q, ref_d, ref_q, hit;

	// ==========================================
	// Hold mux per pin
	genvar g;
	generate
		for (g = 0; g < `PMS_GPIO_COUNT; g++)
		begin : g_pin
			assign out_d[g] = ctl.latch_en ? out_q[g] : gpio_out_i[g];
			assign oe_d[g] = ctl.latch_en ? oe_q[g] : gpio_oe_i[g];
			assign ref_d[g] = ctl.latch_en ? ref_q[g] : pad_in_i[g];
			assign hit[g] = wake_pin_en_i[g] & (pad_in_i[g] ^ ref_q[g]);
		end
	endgenerate

	assign ctl.wake_hit = ctl.latch_en & (|hit);

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			out_q <= '0;
			oe_q <= '0;
			ref_q <= '0;
		end
		else
		begin
			out_q <= out_d;
			oe_q <= oe_d;
			ref_q <= ref_d;
		end
	end

	assign pad_out_o = out_q;
	assign pad_oe_o = oe_q;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_latch_holds_pads: assert property (ctl.latch_en |=> $stable(pad_out_o) && $stable(pad_oe_o))
		else $error("pads moved while latched");
endmodule : io_latch

// ### watchdog_gate.sv
`timescale 1ns/1ps
`include "pms_defs.svh"
module watchdog_gate
	import pms_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Software enable, sticky
	input wire logic watchdog_enable_i,
	// Sequencer link
	pm_ctl_if.wd ctl,
	// Watchdog clock enable
	output logic watchdog_tick_o,
	output logic watchdog_running_o
);
	localparam logic [`PMS_WATCHDOG_ACC_W-1:0] STEP = `PMS_WATCHDOG_ACC_W'(`PMS_WATCHDOG_CLK_KHZ);
	localparam logic [`PMS_WATCHDOG_ACC_W-1:0] WRAP = `PMS_WATCHDOG_ACC_W'(`PMS_SYS_CLK_KHZ);

	logic [`PMS_WATCHDOG_ACC_W-1:0] acc_d, acc_q, sum;
	logic en_d, en_q, tick_d, tick_q;

	// ==========================================
	// Fractional divider, no drift over time
	always_comb
	begin
		sum = acc_q + STEP;
		acc_d = sum;
		tick_d = 1'b0;
		if (sum >= WRAP)
		begin
			acc_d = sum - WRAP;
			tick_d = en_q & ~ctl.wd_pause & ~ctl.wd_off;
		end
		en_d = (en_q | watchdog_enable_i) & ~ctl.wd_off;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			acc_q <= '0;
			en_q <= 1'b0;
			tick_q <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			en_q <= en_d;
			tick_q <= tick_d;
		end
	end

	assign watchdog_tick_o = tick_q;
	assign watchdog_running_o = en_q;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_watchdog_paused: assert property (ctl.wd_pause || ctl.wd_off |=> !watchdog_tick_o)
		else $error("watchdog ticked while paused");
	a_watchdog_sticky: assert property (en_q && !ctl.wd_off |=> en_q)
		else $error("watchdog stopped after enable");
endmodule : watchdog_gate

// ### power_mode_sequencer.sv
// Functional notes
// - Active keeps CPU running with flash, SRAM, peripherals powered and clocked.
// - Idle stops CPU core and memory clocks, peripherals stay clocked.
// - Any interrupt returns idle to active.
// - Standby keeps only always-on domain, sensor power and SRAM retention; supply and brownout duty-cycled.
// - Standby exits only on external, real-time-clock or sensor event, or on the reset pin.
// - Standby wake keeps retained setup and resumes CPU where it stopped.
// - All pins stay latched throughout standby.
// - Shutdown removes all power, clocks, retention and power-on reset.
// - Shutdown freezes pins at their last driven level until wake.
// - A wake-pin level change in shutdown wakes as a reset.
// - Reset cause tells pin wake, reset pin and power-on apart.
// - Shutdown keeps only pin latches and flash; other state lost.
// - Fast clock runs in active and idle, stops in standby, shutdown.
// - Medium clock runs active, idle, standby; stops in shutdown.
// - Slow clock stops only in shutdown or reset held.
// - Reset pin wakes from every mode on release; while held it stays in reset.
// - Full retention active and idle, partial standby, none shutdown.
// - Watchdog runs at fixed rate; once enabled only shutdown or reset held stops it.
// - Watchdog pauses in standby and debug halt, off in shutdown.
`timescale 1ns/1ps
`include "pms_defs.svh"
module power_mode_sequencer
	import pms_pkg::*;
(
	// Clock and power-on reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Reset pin, low while held
	input wire logic rst_pin_n_i,
	// Software mode request
	input wire logic req_i,
	input wire req_mode_type req_mode_i,
	// Wake sources
	input wire logic irq_i,
	input wire logic ext_wake_i,
	input wire logic rtc_wake_i,
	input wire logic sensor_wake_i,
	// Oscillator choice
	input wire logic fast_crystal_osc_sel_i,
	input wire logic slow_crystal_osc_sel_i,
	// Watchdog control
	input wire logic watchdog_enable_i,
	input wire logic debug_halt_i,
	// Pins
	input wire logic [`PMS_GPIO_COUNT-1:0] gpio_out_i,
	input wire logic [`PMS_GPIO_COUNT-1:0] gpio_oe_i,
	input wire logic [`PMS_GPIO_COUNT-1:0] wake_pin_en_i,
	input wire logic [`PMS_GPIO_COUNT-1:0] pad_in_i,
	output logic [`PMS_GPIO_COUNT-1:0] pad_out_o,
	output logic [`PMS_GPIO_COUNT-1:0] pad_oe_o,
	// CPU and memory
	output logic cpu_clk_en_o,
	output logic mem_clk_en_o,
	output logic flash_pwr_o,
	output logic sram_pwr_o,
	output logic sram_retain_o,
	// Peripherals and domains
	output logic periph_pwr_o,
	output logic periph_clk_en_o,
	output logic always_on_domain_pwr_o,
	output logic sensor_pwr_o,
	// Supply supervision
	output logic supply_duty_o,
	output logic brownout_detector_on_o,
	output logic brownout_detector_duty_o,
	output logic por_on_o,
	// Clocks
	output logic high_speed_sys_clock_en_o,
	output logic high_speed_xtal_sel_o,
	output logic medium_speed_sys_clock_en_o,
	output logic low_speed_sys_clock_en_o,
	output logic low_speed_xtal_sel_o,
	// Retention and restart
	output logic state_save_o,
	output logic state_restore_o,
	output logic io_latched_o,
	output logic resume_o,
	output logic boot_o,
	// Status
	output mode_type mode_o,
	output reset_cause_type reset_cause_o,
	output logic system_watchdog_tick_o,
	output logic system_watchdog_running_o
);

	// ==========================================
	// Per-state controls
	function automatic out_type outs_for(input seq_state_type s);
		out_type o;
		logic full_pwr, clk_on, retain, alive;
		o = '0;
		// full retention only while fully powered
		full_pwr = s inside {ST_ACTIVE, ST_IDLE, ST_ENT_LATCH, ST_ENT_SAVE, ST_ENT_GATE,
			ST_EX_PWR, ST_EX_CLK, ST_EX_RESTORE, ST_EX_UNLATCH, ST_BOOT};
		clk_on = full_pwr && !(s inside {ST_ENT_GATE, ST_EX_PWR});
		retain = s inside {ST_ENT_PWR, ST_STANDBY};
		alive = full_pwr || retain;
		o.cpu_clk = (s == ST_ACTIVE);
		o.mem_clk = (s == ST_ACTIVE);
		o.flash = full_pwr;
		o.sram = full_pwr;
		o.periph_pwr = full_pwr;
		o.brown_on = full_pwr;
		o.periph_clk = clk_on;
		o.hs_clk = clk_on;
		o.sram_ret = retain;
		o.supply_duty = retain;
		o.brown_duty = retain;
		o.por_on = alive;
		o.always_on = alive;
		o.sensor = alive;
		o.ms_clk = alive;
		o.ls_clk = alive;
		o.save = (s == ST_ENT_SAVE);
		o.restore = (s == ST_EX_RESTORE);
		// latch from first entry step until the unlatch wake step
		o.latch = s inside {ST_ENT_LATCH, ST_ENT_SAVE, ST_ENT_GATE, ST_ENT_PWR, ST_STANDBY,
			ST_SHUTDOWN, ST_EX_PWR, ST_EX_CLK, ST_EX_RESTORE};
		// pause in standby, off without power
		o.wd_pause = s inside {ST_ENT_PWR, ST_STANDBY, ST_EX_PWR};
		o.wd_off = s inside {ST_SHUTDOWN, ST_RST_HELD};
		unique case (s)
			ST_ACTIVE, ST_ENT_LATCH, ST_ENT_SAVE, ST_EX_UNLATCH: o.mode = MODE_ACTIVE;
			ST_IDLE: o.mode = MODE_IDLE;
			ST_ENT_GATE, ST_ENT_PWR, ST_STANDBY: o.mode = MODE_STANDBY;
			ST_EX_PWR, ST_EX_CLK, ST_EX_RESTORE: o.mode = MODE_STANDBY;
			ST_SHUTDOWN: o.mode = MODE_SHUTDOWN;
			ST_RST_HELD, ST_BOOT: o.mode = MODE_RESET;
		endcase
		return o;
	endfunction : outs_for

	// ==========================================
	// State
	seq_state_type state_d, state_q;
	reset_cause_type cause_d, cause_q;
	out_type out_d, out_q;
	logic to_shutdown_d, to_shutdown_q;
	logic ctx_valid_d, ctx_valid_q;
	logic resume_d, resume_q, boot_d, boot_q;
	logic hs_sel_d, hs_sel_q, ls_sel_d, ls_sel_q;
	logic standby_wake;

	pm_ctl_if ctl ();

	assign standby_wake = ext_wake_i | rtc_wake_i | sensor_wake_i;

	// ==========================================
	// Sequencer next state
	always_comb
	begin
		state_d = state_q;
		cause_d = cause_q;
		to_shutdown_d = to_shutdown_q;
		ctx_valid_d = ctx_valid_q;
		if (!rst_pin_n_i)
		begin
			state_d = ST_RST_HELD;
		end
		else
		begin
			unique case (state_q)
				ST_ACTIVE:
				begin
					// low modes only on software request
					if (req_i)
					begin
						unique case (req_mode_i)
							REQ_IDLE: state_d = ST_IDLE;
							REQ_STANDBY:
							begin
								to_shutdown_d = 1'b0;
								state_d = ST_ENT_LATCH;
							end
							REQ_SHUTDOWN:
							begin
								to_shutdown_d = 1'b1;
								state_d = ST_ENT_LATCH;
							end
							default: state_d = ST_ACTIVE;
						endcase
					end
				end
				ST_IDLE:
				begin
					if (irq_i)
						state_d = ST_ACTIVE;
				end
				// latch, save, gate, then power off
				ST_ENT_LATCH: state_d = ST_ENT_SAVE;
				ST_ENT_SAVE:
				begin
					ctx_valid_d = 1'b1;
					state_d = ST_ENT_GATE;
				end
				ST_ENT_GATE: state_d = ST_ENT_PWR;
				ST_ENT_PWR: state_d = to_shutdown_q ? ST_SHUTDOWN : ST_STANDBY;
				ST_STANDBY:
				begin
					// interrupts alone do not wake standby
					if (standby_wake)
						state_d = ST_EX_PWR;
				end
				// power, clocks, restore, then release pins
				ST_EX_PWR: state_d = ST_EX_CLK;
				ST_EX_CLK: state_d = ST_EX_RESTORE;
				ST_EX_RESTORE: state_d = ST_EX_UNLATCH;
				ST_EX_UNLATCH:
				begin
					ctx_valid_d = 1'b0;
					state_d = ST_ACTIVE;
				end
				ST_SHUTDOWN:
				begin
					ctx_valid_d = 1'b0;
					if (ctl.wake_hit)
					begin
						cause_d = CAUSE_WAKE;
						state_d = ST_BOOT;
					end
				end
				ST_RST_HELD:
				begin
					ctx_valid_d = 1'b0;
					cause_d = CAUSE_PIN;
					state_d = ST_BOOT;
				end
				ST_BOOT: state_d = ST_ACTIVE;
			endcase
		end
	end

	// ==========================================
	// Registered outputs of the next state
	always_comb
	begin
		out_d = outs_for(state_d);
		// resume only from a saved context
		resume_d = (state_q == ST_EX_UNLATCH) && (state_d == ST_ACTIVE) && ctx_valid_q;
		boot_d = (state_q == ST_BOOT);
		// Each source is only taken as its own clock turns back on
		hs_sel_d = out_d.hs_clk && !out_q.hs_clk ? fast_crystal_osc_sel_i : hs_sel_q;
		ls_sel_d = out_d.ls_clk && !out_q.ls_clk ? slow_crystal_osc_sel_i : ls_sel_q;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_BOOT;
			cause_q <= CAUSE_POR;
			to_shutdown_q <= 1'b0;
			ctx_valid_q <= 1'b0;
			out_q <= outs_for(ST_BOOT);
			resume_q <= 1'b0;
			boot_q <= 1'b0;
			hs_sel_q <= 1'b0;
			ls_sel_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cause_q <= cause_d;
			to_shutdown_q <= to_shutdown_d;
			ctx_valid_q <= ctx_valid_d;
			out_q <= out_d;
			resume_q <= resume_d;
			boot_q <= boot_d;
			hs_sel_q <= hs_sel_d;
			ls_sel_q <= ls_sel_d;
		end
	end

	// ==========================================
	// Submodules
	assign ctl.latch_en = out_q.latch;
	assign ctl.wd_pause = out_q.wd_pause | debug_halt_i;
	assign ctl.wd_off = out_q.wd_off;

	io_latch u_io_latch (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.gpio_out_i(gpio_out_i),
		.gpio_oe_i(gpio_oe_i),
		.wake_pin_en_i(wake_pin_en_i),
		.pad_in_i(pad_in_i),
		.pad_out_o(pad_out_o),
		.pad_oe_o(pad_oe_o),
		.ctl(ctl.io)
	);

	watchdog_gate u_watchdog_gate (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.watchdog_enable_i(watchdog_enable_i),
		.ctl(ctl.wd),
		.watchdog_tick_o(system_watchdog_tick_o),
		.watchdog_running_o(system_watchdog_running_o)
	);

	// ==========================================
	// Output mapping
	assign cpu_clk_en_o = out_q.cpu_clk;
	assign mem_clk_en_o = out_q.mem_clk;
	assign flash_pwr_o = out_q.flash;
	assign sram_pwr_o = out_q.sram;
	assign sram_retain_o = out_q.sram_ret;
	assign periph_pwr_o = out_q.periph_pwr;
	assign periph_clk_en_o = out_q.periph_clk;
	assign always_on_domain_pwr_o = out_q.always_on;
	assign sensor_pwr_o = out_q.sensor;
	assign supply_duty_o = out_q.supply_duty;
	assign brownout_detector_on_o = out_q.brown_on;
	assign brownout_detector_duty_o = out_q.brown_duty;
	assign por_on_o = out_q.por_on;
	assign high_speed_sys_clock_en_o = out_q.hs_clk;
	assign high_speed_xtal_sel_o = hs_sel_q;
	assign medium_speed_sys_clock_en_o = out_q.ms_clk;
	assign low_speed_sys_clock_en_o = out_q.ls_clk;
	assign low_speed_xtal_sel_o = ls_sel_q;
	assign state_save_o = out_q.save;
	assign state_restore_o = out_q.restore;
	assign io_latched_o = out_q.latch;
	assign resume_o = resume_q;
	assign boot_o = boot_q;
	assign mode_o = out_q.mode;
	assign reset_cause_o = cause_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence seq_enter_head;
		(state_q == ST_ENT_LATCH) && rst_pin_n_i ##1 rst_pin_n_i;
	endsequence

	sequence seq_exit_head;
		(state_q == ST_STANDBY) && rst_pin_n_i && standby_wake ##1 rst_pin_n_i [*4];
	endsequence

	a_active_running: assert property (state_q == ST_ACTIVE |-> cpu_clk_en_o && flash_pwr_o
		&& sram_pwr_o && periph_clk_en_o)
		else $error("active mode not fully running");
	a_idle_core_off: assert property (state_q == ST_IDLE |-> !cpu_clk_en_o && !mem_clk_en_o
		&& periph_clk_en_o)
		else $error("idle clocks wrong");
	a_idle_irq_wake: assert property ((state_q == ST_IDLE) && irq_i && rst_pin_n_i
		|=> mode_o == MODE_ACTIVE)
		else $error("interrupt did not end idle");
	a_standby_domains: assert property (state_q == ST_STANDBY |-> always_on_domain_pwr_o
		&& !periph_pwr_o && !flash_pwr_o && supply_duty_o && brownout_detector_duty_o)
		else $error("standby domains wrong");
	a_standby_stays: assert property ((state_q == ST_STANDBY) && !standby_wake && rst_pin_n_i
		|=> state_q == ST_STANDBY)
		else $error("standby left without wake source");
	a_enter_order: assert property (seq_enter_head |-> (state_q == ST_ENT_SAVE) && state_save_o
		&& io_latched_o && high_speed_sys_clock_en_o ##1 !high_speed_sys_clock_en_o
		&& periph_pwr_o)
		else $error("entry order broken");
	a_exit_order: assert property (seq_exit_head |-> $past(state_restore_o)
		&& $past(io_latched_o) && $past(high_speed_sys_clock_en_o)
		&& (state_q == ST_EX_UNLATCH) && !io_latched_o ##1 resume_o)
		else $error("wake order or resume broken");
	a_standby_latched: assert property (state_q == ST_STANDBY |-> io_latched_o)
		else $error("pins unlatched in standby");
	a_shutdown_off: assert property (state_q == ST_SHUTDOWN |-> !always_on_domain_pwr_o
		&& !sensor_pwr_o && !por_on_o && !low_speed_sys_clock_en_o && !sram_retain_o
		&& io_latched_o)
		else $error("shutdown left something on");
	a_pin_wake_cause: assert property ((state_q == ST_SHUTDOWN) && rst_pin_n_i && ctl.wake_hit
		|=> (state_q == ST_BOOT) ##1 boot_o && (reset_cause_o == CAUSE_WAKE))
		else $error("pin wake not recorded");
	a_clock_modes: assert property (state_q == ST_STANDBY |-> !high_speed_sys_clock_en_o
		&& medium_speed_sys_clock_en_o && low_speed_sys_clock_en_o)
		else $error("standby clocks wrong");
	a_reset_pin_wake: assert property (!rst_pin_n_i |=> (state_q == ST_RST_HELD)
		&& !low_speed_sys_clock_en_o)
		else $error("reset pin not honoured");
endmodule : power_mode_sequencer

// ### pms_wake_model.sv
`timescale 1ns/1ps
// ==========================================
// Wake sources, pads and reset pin
module pms_wake_model
(
	// Clock
	input wire logic clk_sys_i,
	// Sources: 0 irq, 1 external, 2 rtc, 3 sensor
	output logic [3:0] src_o,
	// Pins
	output logic rst_pin_n_o,
	output logic [31:0] pad_in_o
);
	initial
	begin
		src_o = 4'h0;
		rst_pin_n_o = 1'b1;
		pad_in_o = 32'h0;
	end

	// Levels held two edges so one edge always samples them
	task automatic pulse_src(input int which);
		@(posedge clk_sys_i);
		src_o[which] <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		src_o[which] <= 1'b0;
	endtask : pulse_src

	task automatic flip_pad(input int b);
		@(posedge clk_sys_i);
		pad_in_o[b] <= ~pad_in_o[b];
	endtask : flip_pad

	task automatic hold_reset(input int n);
		@(posedge clk_sys_i);
		rst_pin_n_o <= 1'b0;
		repeat (n) @(posedge clk_sys_i);
		rst_pin_n_o <= 1'b1;
	endtask : hold_reset
endmodule : pms_wake_model

// ### power_mode_sequencer_tb.sv
`timescale 1ns/1ps
module power_mode_sequencer_tb
	import pms_pkg::*;
;
	typedef struct {
		mode_type mode;
		reset_cause_type cause;
		logic [31:0] pad;
		logic full;
		int res;
		int boot;
	} exp_type;

	logic clk_sys_i, rst_i, req_i, wd_en, halt, fx, sx;
	req_mode_type req_mode_i;
	logic [31:0] gpio_out, gpio_oe, wake_en, pad_in, pad_out, pad_oe, hold, g, seed;
	logic [3:0] src;
	logic rst_pin_n;
	wire [16:0] dom;
	mode_type mode, prev;
	reset_cause_type cause;
	logic resume, boot, tick, running, hs_sel, ls_sel;
	exp_type q[$];
	exp_type e;
	int num_errors, n_checks, stable, nres, nboot, ticks, t0, cyc, k;

	// ==========================================
	// Design and far side
	power_mode_sequencer dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rst_pin_n_i(rst_pin_n),
		.req_i(req_i), .req_mode_i(req_mode_i), .irq_i(src[0]), .ext_wake_i(src[1]),
		.rtc_wake_i(src[2]), .sensor_wake_i(src[3]), .fast_crystal_osc_sel_i(fx),
		.slow_crystal_osc_sel_i(sx), .watchdog_enable_i(wd_en), .debug_halt_i(halt),
		.gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .wake_pin_en_i(wake_en), .pad_in_i(pad_in),
		.pad_out_o(pad_out), .pad_oe_o(pad_oe), .cpu_clk_en_o(dom[16]), .mem_clk_en_o(dom[15]),
		.flash_pwr_o(dom[14]), .sram_pwr_o(dom[13]), .sram_retain_o(dom[12]),
		.periph_pwr_o(dom[11]), .periph_clk_en_o(dom[10]), .always_on_domain_pwr_o(dom[9]),
		.sensor_pwr_o(dom[8]), .supply_duty_o(dom[7]), .brownout_detector_on_o(dom[6]),
		.brownout_detector_duty_o(dom[5]), .por_on_o(dom[4]), .high_speed_sys_clock_en_o(dom[3]),
		.high_speed_xtal_sel_o(hs_sel), .medium_speed_sys_clock_en_o(dom[2]),
		.low_speed_sys_clock_en_o(dom[1]), .low_speed_xtal_sel_o(ls_sel), .state_save_o(),
		.state_restore_o(), .io_latched_o(dom[0]), .resume_o(resume), .boot_o(boot),
		.mode_o(mode), .reset_cause_o(cause), .system_watchdog_tick_o(tick),
		.system_watchdog_running_o(running));
	pms_wake_model wk (.clk_sys_i(clk_sys_i), .src_o(src), .rst_pin_n_o(rst_pin_n),
		.pad_in_o(pad_in));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// ==========================================
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [16:0] dom_of(input mode_type m);
		logic full;
		logic sb;
		logic on;
		full = (m == MODE_ACTIVE) || (m == MODE_IDLE);
		sb = (m == MODE_STANDBY);
		on = full || sb;
		return {m == MODE_ACTIVE, m == MODE_ACTIVE, full, full, sb, full, full, on, on, sb, full,
			sb, on, full, on, on, sb || (m == MODE_SHUTDOWN)};
	endfunction : dom_of

	task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, ex, got);
		end
	endtask : chk

	task automatic expect_mode(input mode_type m, input reset_cause_type c, input logic f,
		input int r, input int b);
		q.push_back('{m, c, g, f, r, b});
	endtask : expect_mode

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : wait_n

	task automatic set_gpio();
		g = xs();
		@(posedge clk_sys_i);
		gpio_out <= g;
		gpio_oe <= ~g;
	endtask : set_gpio

	task automatic go(input req_mode_type r);
		@(posedge clk_sys_i);
		req_i <= 1'b1;
		req_mode_i <= r;
		@(posedge clk_sys_i);
		req_i <= 1'b0;
		wait_n(14);
	endtask : go

	task automatic summarize();
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	// ==========================================
	// Monitor: a mode that holds six cycles is a settled result
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (tick === 1'b1)
			ticks++;
		if (resume === 1'b1)
			nres++;
		if (boot === 1'b1)
			nboot++;
		stable = (mode !== prev) ? 0 : stable + 1;
		prev = mode;
		if (stable == 6 && rst_i === 1'b0)
		begin
			chk("pending", 32'h1, 32'(q.size() > 0));
			if (q.size() > 0)
			begin
				e = q.pop_front();
				chk("mode", e.mode, mode);
				chk("domains", dom_of(e.mode), dom);
				chk("resume", e.res, nres);
				chk("boot", e.boot, nboot);
				if (e.full)
					chk("cause", e.cause, cause);
				if (e.full)
					chk("pads", e.pad, pad_out);
				if (e.full)
					chk("pad_oe", ~e.pad, pad_oe);
			end
			nres = 0;
			nboot = 0;
		end
		if (cyc == 4000)
		begin
			num_errors++;
			summarize();
		end
	end

	// ==========================================
	// Main sequence
	initial
	begin
		seed = 32'h4eab;
		rst_i = 1'b1;
		req_i = 1'b0;
		req_mode_i = REQ_IDLE;
		wd_en = 1'b0;
		halt = 1'b0;
		gpio_out = xs();
		gpio_oe = ~gpio_out;
		fx = seed[3];
		sx = seed[7];
		wake_en = 32'h0;
		g = gpio_out;
		expect_mode(MODE_ACTIVE, CAUSE_POR, 1'b1, 0, 1);
		wait_n(2);
		rst_i <= 1'b0;
		wait_n(12);
		@(posedge clk_sys_i);
		wd_en <= 1'b1;
		@(posedge clk_sys_i);
		wd_en <= 1'b0;
		wait_n(20);
		t0 = ticks;
		wait_n(100);
		chk("wd_rate", 32'h1, 32'(ticks - t0 >= 5 && ticks - t0 <= 7));
		chk("wd_running", 32'h1, 32'(running));
		@(posedge clk_sys_i);
		halt <= 1'b1;
		wait_n(3);
		t0 = ticks;
		wait_n(50);
		chk("wd_halted", t0, ticks);
		halt <= 1'b0;
		set_gpio();
		expect_mode(MODE_IDLE, CAUSE_POR, 1'b1, 0, 0);
		go(REQ_IDLE);
		expect_mode(MODE_ACTIVE, CAUSE_POR, 1'b1, 0, 0);
		wk.pulse_src(0);
		wait_n(14);
		@(posedge clk_sys_i);
		req_i <= 1'b1;
		req_mode_i <= req_mode_type'(2'h3);
		@(posedge clk_sys_i);
		req_i <= 1'b0;
		wait_n(12);
		chk("code3_ignored", MODE_ACTIVE, mode);
		for (int s = 1; s <= 3; s++)
		begin
			set_gpio();
			fx <= s[0];
			expect_mode(MODE_STANDBY, CAUSE_POR, 1'b1, 0, 0);
			go(REQ_STANDBY);
			t0 = ticks;
			wk.pulse_src(0);
			wait_n(8);
			chk("irq_in_standby", MODE_STANDBY, mode);
			hold = g;
			set_gpio();
			wait_n(4);
			chk("pads_held", hold, pad_out);
			chk("oe_held", ~hold, pad_oe);
			chk("wd_paused", t0, ticks);
			expect_mode(MODE_ACTIVE, CAUSE_POR, 1'b1, 1, 0);
			wk.pulse_src(s);
			wait_n(16);
			chk("hs_source", s[0], hs_sel);
		end
		k = int'(xs() & 32'h1f);
		@(posedge clk_sys_i);
		wake_en <= 32'h1 << k;
		sx <= 1'b1;
		set_gpio();
		expect_mode(MODE_SHUTDOWN, CAUSE_POR, 1'b1, 0, 0);
		go(REQ_SHUTDOWN);
		chk("wd_off", 32'h0, 32'(running));
		wk.pulse_src(1);
		wk.flip_pad((k + 1) % 32);
		wk.pulse_src(0);
		wait_n(8);
		chk("shutdown_held", MODE_SHUTDOWN, mode);
		expect_mode(MODE_ACTIVE, CAUSE_WAKE, 1'b1, 0, 1);
		wk.flip_pad(k);
		wait_n(16);
		chk("ls_source", 32'h1, ls_sel);
		set_gpio();
		expect_mode(MODE_STANDBY, CAUSE_WAKE, 1'b1, 0, 0);
		go(REQ_STANDBY);
		sx <= 1'b0;
		expect_mode(MODE_RESET, CAUSE_WAKE, 1'b0, 0, 0);
		expect_mode(MODE_ACTIVE, CAUSE_PIN, 1'b1, 0, 1);
		wk.hold_reset(12);
		wait_n(16);
		chk("ls_source_pin", 32'h0, ls_sel);
		chk("all_settled", 32'h0, 32'(q.size()));
		summarize();
	end
endmodule : power_mode_sequencer_tb
